// ===== design/dtf_pkg.sv
// Purpose: constants for the training FIFO and strobe-tree interval oscillator
// Assumes: AHB-Lite register map, one word per register
// Notes:   shared by the top and the oscillator counter
package dtf_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_OSC_RUN    = 8'h04;
  localparam logic [7:0] OFS_OSC_LOW    = 8'h08;
  localparam logic [7:0] OFS_OSC_HIGH   = 8'h0C;
  localparam logic [7:0] OFS_STATUS     = 8'h10;
  // ==========================================================
  // control field positions
  localparam int CTRL_WL_LSB   = 0;
  localparam int CTRL_RL_LSB   = 8;
  localparam int CTRL_WDBI_BIT = 16;
  localparam int CTRL_RDBI_BIT = 17;
  localparam int CTRL_DM_BIT   = 18;
  localparam int LAT_W         = 6;
  // status field positions
  localparam int STAT_WPTR_LSB = 0;
  localparam int STAT_RPTR_LSB = 4;
  localparam int STAT_RUN_BIT  = 8;
  // ==========================================================
  // reset values
  localparam logic [5:0]  WL_RESET      = 6'h04;
  localparam logic [5:0]  RL_RESET      = 6'h06;
  localparam logic [7:0]  RUN_RESET     = 8'h00;
  localparam logic [15:0] OSC_RES_RESET = 16'h0000;
  // ==========================================================
  // sizes and limits
  localparam int          FIFO_DEPTH    = 5;
  localparam int          PTR_W         = 3;
  localparam int          OSC_W         = 16;
  localparam logic [15:0] OSC_MAX       = 16'hFFFF;
  localparam int          WR_TAP_OFS    = 1;
  localparam int          RD_TAP_OFS    = 2;
  // ==========================================================
  // oscillator states
  typedef enum logic [1:0] {
    DTF_OSC_IDLE = 2'b01,
    DTF_OSC_RUN  = 2'b10
  } dtf_osc_state_e;
endpackage

// ===== design/dtf_osc_counter.sv
// Purpose: interval oscillator counter with command and automatic stop
// Assumes: ring tick arrives from the replica tree, unrelated to clk_sys
// Notes:   result saturates; held until next stop
`timescale 1ns/1ps
`default_nettype none
module dtf_osc_counter
  import dtf_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // commands and setting
  input  wire logic             osc_start,
  input  wire logic             osc_stop,
  input  wire logic [7:0]       run_count,
  input  wire logic             ring_tick_async,
  // result
  output logic      [OSC_W-1:0] osc_result,
  output logic                  osc_running,
  output logic                  osc_done
);
  // ==========================================================
  // tick synchroniser and edge
  logic             tick_s1;
  logic             tick_s2;
  logic             tick_s3;
  dtf_osc_state_e   state;
  dtf_osc_state_e   next_state;
  logic [OSC_W-1:0] count;
  logic [7:0]       clk_cnt;
  logic [7:0]       run_lat;
  wire              tick_edge = tick_s2 & ~tick_s3;
  wire              running   = (state == DTF_OSC_RUN);
  wire              auto_mode = (run_lat != 8'h00);
  // auto mode ignores the stop command, it is illegal there
  wire              cmd_end   = osc_stop & ~auto_mode;
  wire              auto_end  = auto_mode & (clk_cnt == run_lat - 8'h01);
  wire              finish    = running & (cmd_end | auto_end);
  wire              at_max    = (count == OSC_MAX);

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      tick_s1 <= 1'b0;
      tick_s2 <= 1'b0;
      tick_s3 <= 1'b0;
    end
    else
    begin
      tick_s1 <= ring_tick_async;
      tick_s2 <= tick_s1;
      tick_s3 <= tick_s2;
    end

  // ==========================================================
  // state machine
  always_comb
  begin
    next_state = state;
    case (state)
      DTF_OSC_IDLE: if (osc_start) next_state = DTF_OSC_RUN;
      DTF_OSC_RUN:  if (finish) next_state = DTF_OSC_IDLE;
      default:      next_state = DTF_OSC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      state      <= DTF_OSC_IDLE;
      count      <= '0;
      clk_cnt    <= 8'h00;
      run_lat    <= RUN_RESET;
      osc_result <= OSC_RES_RESET;
      osc_done   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      osc_done <= finish;
      if (osc_start && !running)
      begin
        count   <= '0;
        clk_cnt <= 8'h00;
        run_lat <= run_count;
      end
      else if (running)
      begin
        clk_cnt <= clk_cnt + 8'h01;
        if (tick_edge && !at_max)
          count <= count + 16'h0001;
      end
      if (finish)
        osc_result <= count;
    end

  assign osc_running = running;

  // ==========================================================
  // checks
  a_osc_saturate: assert property (@(posedge clk_sys) disable iff (!arst_n)
    at_max && running |=> count == OSC_MAX)
    else $error("oscillator count left its maximum");
  a_osc_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
    finish |=> osc_result == $past(count) && osc_done && !osc_running)
    else $error("result not stored on stop");
  a_osc_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    osc_start && !running |=> count == '0 && osc_running)
    else $error("counter not cleared on start");
  a_osc_auto: assert property (@(posedge clk_sys) disable iff (!arst_n)
    osc_start && !running && run_count == 8'h03 ##1 (!osc_start)[*3] |=> !osc_running)
    else $error("automatic stop missed");
endmodule
`default_nettype wire

// ===== design/dtf_top.sv
// Purpose: training FIFO with pointers, latency pipes and oscillator, AHB-Lite regs
// Assumes: command strobes are decoded on clk_sys, one cycle each
// Notes:   latencies count clk_sys cycles from the command cycle
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dtf_top
  import dtf_pkg::*;
#(
  parameter int DATA_W  = 256,
  parameter int DMI_W   = 32,
  parameter int MAX_LAT = 64
)(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  // decoded commands
  input  wire logic              cmd_wr_fifo,
  input  wire logic              cmd_rd_fifo,
  input  wire logic              cmd_read,
  input  wire logic              cmd_osc_start,
  input  wire logic              cmd_osc_stop,
  input  wire logic              pd_entry,
  input  wire logic              sref_pd_entry,
  // write data path
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [DMI_W-1:0]  wr_dmi,
  output logic                   wr_beat,
  output logic                   odt_on,
  // read data path
  output logic      [DATA_W-1:0] rd_data,
  output logic      [DMI_W-1:0]  rd_dmi,
  output logic                   rd_valid,
  output logic                   dmi_oe_n,
  // replica oscillator
  input  wire logic              ring_tick_async,
  output logic                   osc_done
);
  localparam int ENTRY_W = DATA_W + DMI_W;

  if (DATA_W < 1 || DMI_W < 1 || MAX_LAT < 2 || MAX_LAT > 64)
  begin : g_chk
    $error("dtf_top: unsupported parameter values");
  end

  // ==========================================================
  // helpers
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : p + 3'd1;
  endfunction

  function automatic logic [LAT_W-1:0] lat_tap(input logic [LAT_W-1:0] lat,
                                               input logic [LAT_W-1:0] ofs);
    lat_tap = (lat <= ofs) ? '0 : lat - ofs;
  endfunction

  // ==========================================================
  // registers
  logic [LAT_W-1:0]               wl;
  logic [LAT_W-1:0]               rl;
  logic                           wdbi_en;
  logic                           rdbi_en;
  logic                           dm_en;
  logic [7:0]                     osc_run_count_reg;
  logic [PTR_W-1:0]               wr_ptr;
  logic [PTR_W-1:0]               rd_ptr;
  logic [FIFO_DEPTH-1:0][ENTRY_W-1:0] fifo_mem;
  logic [MAX_LAT-1:0]             wr_pv;
  logic [MAX_LAT-1:0]             rd_pv;
  logic [MAX_LAT-1:0][PTR_W-1:0]  wr_pp;
  logic [MAX_LAT-1:0][PTR_W-1:0]  rd_pp;
  logic                           dph_wr;
  logic [7:0]                     dph_addr;
  logic [OSC_W-1:0]               osc_result;
  logic                           osc_running;

  // ==========================================================
  // pointer control
  wire              flush    = pd_entry | sref_pd_entry;
  // write-FIFO has no bank, refresh or self-refresh gating
  wire              wr_adv   = cmd_wr_fifo | cmd_read;
  wire              rd_adv   = cmd_rd_fifo | cmd_read;
  wire [PTR_W-1:0]  next_wr_ptr = flush ? '0 : (wr_adv ? ptr_inc(wr_ptr) : wr_ptr);
  wire [PTR_W-1:0]  next_rd_ptr = flush ? '0 : (rd_adv ? ptr_inc(rd_ptr) : rd_ptr);

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end

  // ==========================================================
  // latency pipes, one slot per cycle so commands can run back to back
  wire [LAT_W-1:0]  wr_tap  = lat_tap(wl, LAT_W'(WR_TAP_OFS));
  wire [LAT_W-1:0]  rd_tap  = lat_tap(rl, LAT_W'(RD_TAP_OFS));
  wire              wr_hit  = wr_pv[wr_tap];
  wire [PTR_W-1:0]  wr_slot = wr_pp[wr_tap];
  wire              rd_hit  = rd_pv[rd_tap];
  wire [PTR_W-1:0]  rd_slot = rd_pp[rd_tap];
  wire              dmi_any = wdbi_en | rdbi_en | dm_en;

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      wr_pv <= '0;
      rd_pv <= '0;
      wr_pp <= '0;
      rd_pp <= '0;
    end
    else
    begin
      wr_pv <= {wr_pv[MAX_LAT-2:0], cmd_wr_fifo};
      rd_pv <= {rd_pv[MAX_LAT-2:0], cmd_rd_fifo};
      wr_pp <= {wr_pp[MAX_LAT-2:0], wr_ptr};
      rd_pp <= {rd_pp[MAX_LAT-2:0], rd_ptr};
    end

  // storage has no reset, so unwritten entries return whatever they hold
  always_ff @(posedge clk_sys)
    if (wr_hit)
      fifo_mem[wr_slot] <= {wr_dmi, wr_data};

  assign wr_beat = wr_hit;
  assign odt_on  = wr_hit;

  // reads only index the storage, never write it back
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
      rd_dmi   <= '0;
      dmi_oe_n <= 1'b1;
    end
    else
    begin
      rd_valid <= rd_hit;
      dmi_oe_n <= ~(rd_hit & dmi_any);
      if (rd_hit)
        {rd_dmi, rd_data} <= fifo_mem[rd_slot];
    end

  // ==========================================================
  // oscillator
  dtf_osc_counter u_osc (
    .clk_sys         (clk_sys),
    .arst_n          (arst_n),
    .osc_start       (cmd_osc_start),
    .osc_stop        (cmd_osc_stop),
    .run_count       (osc_run_count_reg),
    .ring_tick_async (ring_tick_async),
    .osc_result      (osc_result),
    .osc_running     (osc_running),
    .osc_done        (osc_done)
  );

  // ==========================================================
  // AHB-Lite slave, zero wait states
  wire        addr_ok  = hsel & hready & htrans[1];
  wire        do_write = dph_wr;
  wire [31:0] ctrl_word = {13'h0000, dm_en, rdbi_en, wdbi_en, 2'b00, rl, 2'b00, wl};
  wire [31:0] stat_word = {23'h00_0000, osc_running, 1'b0, rd_ptr, 1'b0, wr_ptr};
  wire [31:0] rd_mux =
    (haddr[7:0] == OFS_CTRL)     ? ctrl_word :
    (haddr[7:0] == OFS_OSC_RUN)  ? {24'h00_0000, osc_run_count_reg} :
    (haddr[7:0] == OFS_OSC_LOW)  ? {24'h00_0000, osc_result[7:0]} :
    (haddr[7:0] == OFS_OSC_HIGH) ? {24'h00_0000, osc_result[15:8]} :
    (haddr[7:0] == OFS_STATUS)   ? stat_word : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      dph_wr   <= 1'b0;
      dph_addr <= 8'h00;
      hrdata   <= 32'h0000_0000;
    end
    else
    begin
      dph_wr   <= addr_ok & hwrite;
      dph_addr <= haddr[7:0];
      if (addr_ok && !hwrite)
        hrdata <= rd_mux;
    end

  // written at the end of the data phase; a read in the next cycle sees it
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      wl                <= WL_RESET;
      rl                <= RL_RESET;
      wdbi_en           <= 1'b0;
      rdbi_en           <= 1'b0;
      dm_en             <= 1'b0;
      osc_run_count_reg <= RUN_RESET;
    end
    else if (do_write)
    begin
      if (dph_addr == OFS_CTRL)
      begin
        wl      <= hwdata[CTRL_WL_LSB +: LAT_W];
        rl      <= hwdata[CTRL_RL_LSB +: LAT_W];
        wdbi_en <= hwdata[CTRL_WDBI_BIT];
        rdbi_en <= hwdata[CTRL_RDBI_BIT];
        dm_en   <= hwdata[CTRL_DM_BIT];
      end
      if (dph_addr == OFS_OSC_RUN)
        osc_run_count_reg <= hwdata[7:0];
    end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ==========================================================
  // checks
  sequence s_rd_cmd_default;
    cmd_rd_fifo && rl == RL_RESET && !flush;
  endsequence
  sequence s_wr_cmd_default;
    cmd_wr_fifo && wl == WL_RESET;
  endsequence

  a_ptr_flush: assert property (@(posedge clk_sys) disable iff (!arst_n)
    flush |=> wr_ptr == '0 && rd_ptr == '0)
    else $error("pointers not cleared on power-down entry");
  a_wrcmd_only_wr: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cmd_wr_fifo && !cmd_read && !cmd_rd_fifo && !flush
      |=> wr_ptr == ptr_inc($past(wr_ptr)) && $stable(rd_ptr))
    else $error("write-FIFO moved the wrong pointer");
  a_rdcmd_only_rd: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cmd_rd_fifo && !cmd_read && !cmd_wr_fifo && !flush
      |=> rd_ptr == ptr_inc($past(rd_ptr)) && $stable(wr_ptr))
    else $error("read-FIFO moved the wrong pointer");
  a_read_both: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cmd_read && !flush
      |=> wr_ptr == ptr_inc($past(wr_ptr)) && rd_ptr == ptr_inc($past(rd_ptr)))
    else $error("normal read did not move both pointers");
  a_rd_wrap: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_ptr == 3'd4 && rd_adv && !flush |=> rd_ptr == 3'd0)
    else $error("read pointer did not wrap after five");
  a_no_rd_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !wr_hit |=> $stable(fifo_mem))
    else $error("storage changed without a write beat");
  a_wr_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_hit |=> fifo_mem[$past(wr_slot)] == $past({wr_dmi, wr_data}))
    else $error("write beat not stored at its slot");
  a_wr_latency: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_wr_cmd_default ##1 (wl == WL_RESET)[*3] |=> wr_beat && odt_on)
    else $error("write beat not at write latency");
  a_rd_latency: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_rd_cmd_default ##1 (rl == RL_RESET)[*5] |=> rd_valid)
    else $error("read data not at read latency");
  a_dmi_drive: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_hit |=> dmi_oe_n == !$past(dmi_any) && rd_valid)
    else $error("mask pins not driven with enabled function");
endmodule
`default_nettype wire

// ===== verification/dtf_ctrl_model.sv
// Purpose: controller-side model issuing decoded training commands
// Assumes: every command reaches the block as a one-cycle strobe on clk_sys
// Notes:   idle data lines toggle every cycle, inverting their previous value
`timescale 1ns/1ps
`default_nettype none
module dtf_ctrl_model
#(
  parameter int DW = 28,
  parameter int MW = 4
)(
  // clock and beat flag
  input  wire logic          clk_sys,
  input  wire logic          wr_beat,
  // strobes, burst data, replica edges
  output var  logic [6:0]    cmd,
  output var  logic [DW-1:0] wr_data,
  output var  logic [MW-1:0] wr_dmi,
  output var  logic          ring_tick_async
);
  logic [DW-1:0] q[$];

  initial
  begin
    cmd = 7'h00;
    wr_data = '0;
    wr_dmi = '0;
    ring_tick_async = 1'b0;
  end

  // ====================
  // burst data
  // 1 ns after the edge, so the beat flag of this cycle has settled
  always @(posedge clk_sys)
  begin
    #1;
    if (wr_beat === 1'b1 && q.size() > 0)
      wr_data = q.pop_front();
    else
      wr_data = ~wr_data;
    wr_dmi = wr_data[DW-1 -: MW];
  end

  task automatic load(input logic [DW-1:0] d);
    q.push_back(d);
  endtask

  // ====================
  // command strobes
  // pairs arrive decoded, so trailing operands are low by construction
  // n strobes back to back; only fifo commands inside training
  task automatic issue(input int k, input int n);
    @(posedge clk_sys);
    cmd[k] <= 1'b1;
    repeat (n) @(posedge clk_sys);
    cmd[k] <= 1'b0;
  endtask

  // replica edges, each level held three clocks; line rests low between runs
  task automatic ticks(input int n);
    repeat (n)
    begin
      ring_tick_async <= 1'b1;
      repeat (3) @(posedge clk_sys);
      ring_tick_async <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// ===== verification/test_dram_training_fifo_dqs_osc.sv
// Purpose: self-checking bench for the training fifo and oscillator
// Assumes: narrow data path, zero-wait register bus
// Notes:   latencies judged by edge time differences
`timescale 1ns/1ps
`default_nettype none
module test_dram_training_fifo_dqs_osc;
  import dtf_pkg::*;
  localparam int DW = 28;
  localparam int MW = 4;
  localparam int WF = 0;
  localparam int RF = 1;
  localparam int RD = 2;
  localparam int OST = 3;
  localparam int OSP = 4;
  localparam int PD = 5;
  localparam int SPD = 6;
  localparam logic [32:0] DC = 33'h1_0000_0000;
  logic          clk_sys, arst_n, hsel, hwrite, hreadyout, hresp;
  logic          wr_beat, odt_on, rd_valid, dmi_oe_n, ring_tick_async, osc_done;
  logic [1:0]    htrans;
  logic [2:0]    hsize, en;
  logic [31:0]   haddr, hwdata, hrdata;
  logic [6:0]    cmd;
  logic [DW-1:0] wr_data, rd_data;
  logic [MW-1:0] wr_dmi, rd_dmi;
  int            error_cnt, samples_checked, wl, rl;
  time           wq[$];
  time           rq[$];
  logic [32:0]   eq[$];

  dtf_top
  #(
    .DATA_W (DW),
    .DMI_W  (MW)
  ) u_dtf_top (
    .clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready (hreadyout), .hreadyout, .hresp, .hrdata,
    .cmd_wr_fifo (cmd[WF]), .cmd_rd_fifo (cmd[RF]), .cmd_read (cmd[RD]),
    .cmd_osc_start (cmd[OST]), .cmd_osc_stop (cmd[OSP]),
    .pd_entry (cmd[PD]), .sref_pd_entry (cmd[SPD]),
    .wr_data, .wr_dmi, .wr_beat, .odt_on, .rd_data, .rd_dmi, .rd_valid,
    .dmi_oe_n, .ring_tick_async, .osc_done
  );

  dtf_ctrl_model
  #(
    .DW (DW),
    .MW (MW)
  ) u_dtf_ctrl_model (
    .clk_sys, .wr_beat, .cmd, .wr_data, .wr_dmi, .ring_tick_async
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ====================
  // compare and verdict
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // run is under two thousand cycles; the 30000-cycle limit cuts a hang
  initial
  begin
    #150_000;
    error_cnt++;
    conclude();
  end

  // ====================
  // bus master
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
      error_cnt++;
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string w);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0000_0000, v);
    chk(w, e, v);
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask

  task automatic setcfg(input int w, input int r, input logic [2:0] e);
    wl = w;
    rl = r;
    en = e;
    wreg(OFS_CTRL, {13'h0000, e, 2'b00, r[5:0], 2'b00, w[5:0]});
    rchk(OFS_CTRL, {13'h0000, e, 2'b00, r[5:0], 2'b00, w[5:0]}, "ctrl");
  endtask

  function automatic logic [DW-1:0] bst(input int i);
    return DW'(i * 32'h0111_1111 + 32'h00ED_CBA0);
  endfunction

  function automatic logic [32:0] ent(input int i);
    logic [DW-1:0] b;
    b = bst(i);
    return {1'b0, b[DW-1 -: MW], b};
  endfunction

  // ====================
  // data path monitor
  always @(posedge clk_sys)
  begin
    logic [32:0] e;
    if (cmd[WF] === 1'b1)
      wq.push_back($time);
    if (cmd[RF] === 1'b1)
      rq.push_back($time);
    if ((wr_beat | odt_on) === 1'b1)
    begin
      chk("odt window", {31'h0, wr_beat}, {31'h0, odt_on});
      chk("write latency", wl * 5, 32'($time - wq.pop_front()));
    end
    if (rd_valid === 1'b1)
    begin
      e = eq.pop_front();
      chk("read latency", rl * 5, 32'($time - rq.pop_front()));
      chk("mask drive", {31'h0, ~|en}, {31'h0, dmi_oe_n});
      if (e[32] === 1'b0)
        chk("read entry", e[31:0], {rd_dmi, rd_data});
    end
  end

  // ====================
  // scenarios
  task automatic s_regs();
    rchk(OFS_CTRL, 32'h0000_0604, "ctrl reset");
    rchk(OFS_OSC_LOW, 32'h0000_0000, "low reset");
    rchk(OFS_OSC_HIGH, 32'h0000_0000, "high reset");
    rchk(OFS_STATUS, 32'h0000_0000, "status reset");
    rchk(8'h14, 32'h0000_0000, "unmapped");
    wreg(OFS_OSC_LOW, 32'h0000_00FF);
    rchk(OFS_OSC_LOW, 32'h0000_0000, "low read only");
    wreg(OFS_OSC_RUN, 32'h0000_00A5);
    rchk(OFS_OSC_RUN, 32'h0000_00A5, "run count");
    wreg(OFS_OSC_RUN, 32'h0000_0000);
  endtask

  task automatic s_burst();
    for (int i = 0; i < 6; i++)
      u_dtf_ctrl_model.load(bst(i));
    u_dtf_ctrl_model.issue(WF, 6);
    tick(wl + 3);
    rchk(OFS_STATUS, 32'h0000_0001, "ptr after writes");
    for (int i = 0; i < 11; i++)
      eq.push_back(ent((i % 5 == 0) ? 5 : i % 5));
    u_dtf_ctrl_model.issue(RF, 11);
    tick(rl + 3);
    rchk(OFS_STATUS, 32'h0000_0011, "ptr after reads");
  endtask

  task automatic s_partial();
    u_dtf_ctrl_model.issue(PD, 1);
    tick(2);
    rchk(OFS_STATUS, 32'h0000_0000, "ptr after pd");
    setcfg(1, 2, 3'b100);
    for (int i = 0; i < 3; i++)
      u_dtf_ctrl_model.load(bst(10 + i));
    u_dtf_ctrl_model.issue(WF, 3);
    tick(3);
    for (int i = 0; i < 8; i++)
      eq.push_back((i % 5 > 2) ? DC : ent(10 + i % 5));
    u_dtf_ctrl_model.issue(RF, 8);
    tick(4);
    u_dtf_ctrl_model.issue(RD, 1);
    tick(2);
    rchk(OFS_STATUS, 32'h0000_0044, "ptr after read");
    u_dtf_ctrl_model.issue(SPD, 1);
    tick(2);
    rchk(OFS_STATUS, 32'h0000_0000, "ptr after sref pd");
  endtask

  task automatic s_dmi();
    logic [2:0] m [4];
    m = '{3'b000, 3'b001, 3'b010, 3'b100};
    for (int i = 0; i < 4; i++)
    begin
      setcfg(3, 4, m[i]);
      eq.push_back(DC);
      u_dtf_ctrl_model.issue(RF, 1);
      tick(6);
    end
  endtask

  task automatic s_rst();
    u_dtf_ctrl_model.issue(WF, 2);
    tick(wl + 3);
    rchk(OFS_STATUS, 32'h0000_0042, "ptr before reset");
    arst_n <= 1'b0;
    tick(2);
    arst_n <= 1'b1;
    wl = 4;
    rl = 6;
    en = 3'b000;
    rchk(OFS_STATUS, 32'h0000_0000, "ptr after reset");
    rchk(OFS_CTRL, 32'h0000_0604, "ctrl after reset");
  endtask

  // waits for the done pulse and judges the run length in cycles
  task automatic osc_wait(input time t0, input int c, input string w);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (osc_done !== 1'b1 && n < 100);
    chk(w, c * 5, 32'($time - t0));
  endtask

  task automatic s_osc();
    time t0;
    u_dtf_ctrl_model.issue(OST, 1);
    u_dtf_ctrl_model.ticks(260);
    tick(4);
    rchk(OFS_STATUS, 32'h0000_0100, "osc running");
    u_dtf_ctrl_model.issue(OSP, 1);
    tick(4);
    rchk(OFS_OSC_LOW, 32'h0000_0004, "count low");
    rchk(OFS_OSC_HIGH, 32'h0000_0001, "count high");
    wreg(OFS_OSC_RUN, 32'h0000_0028);
    u_dtf_ctrl_model.issue(OST, 1);
    t0 = $time;
    u_dtf_ctrl_model.ticks(3);
    osc_wait(t0, 41, "auto stop");
    rchk(OFS_OSC_LOW, 32'h0000_0003, "restart low");
    rchk(OFS_OSC_HIGH, 32'h0000_0000, "restart high");
    rchk(OFS_STATUS, 32'h0000_0000, "osc stopped");
    // short run of three clocks, no replica edges: result must clear
    wreg(OFS_OSC_RUN, 32'h0000_0003);
    u_dtf_ctrl_model.issue(OST, 1);
    t0 = $time;
    osc_wait(t0, 4, "short auto stop");
    rchk(OFS_OSC_LOW, 32'h0000_0000, "short low");
    rchk(OFS_STATUS, 32'h0000_0000, "short stopped");
  endtask

  // ====================
  // main sequence
  initial
  begin
    error_cnt = 0;
    samples_checked = 0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    arst_n = 1'b0;
    wl = 4;
    rl = 6;
    en = 3'b000;
    tick(20);
    arst_n <= 1'b1;
    s_regs();
    s_burst();
    s_partial();
    s_dmi();
    s_rst();
    s_osc();
    chk("pending reads", 32'h0000_0000, 32'(eq.size()));
    chk("pending beats", 32'h0000_0000, 32'(wq.size()));
    conclude();
  end
endmodule
`default_nettype wire
